// file: common/nvd_pkg.sv
// Purpose: Shared constants and types for the non-volatile register
//          command descriptor block.
// Assumes: 32-bit AXI4-Lite data, 8-bit byte address.
// Notes:   Functional notes below; tags mark the logic that keeps them.
// Functional notes
// [R01] Bit 31: non-volatile register read supported.
// [R02] Bit 30: non-volatile register write supported.
// [R03] Bits 29:28: address bytes, codes give 1..4.
// [R04] Host sizes register address apart from array.
// [R05] Bits 27:26: single-lane dummy none/byte/count/unsupported.
// [R06] Bits 3:0: single-lane count, all ones unsupported.
// [R07] Bits 25:22: dual-lane dummy cycles, ones unsupported.
// [R08] Bits 21:18: quad single-rate dummy cycles.
// [R09] Bits 17:14: quad double-rate address/data dummy.
// [R10] Bits 13:10: octal single-rate dummy cycles.
// [R11] Bits 9:6: octal double-rate dummy cycles.
// [R12] Bits 5:4 reserved, reported zero, host ignores.
// [R13] Host sequences opcode, address, dummy, data; blocks unsupported.
package nvd_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0]  NVD_OFS_DESC    = 8'h00;
   localparam logic [7:0]  NVD_OFS_CFG     = 8'h04;
   localparam logic [7:0]  NVD_OFS_DECODE  = 8'h08;
   localparam logic [7:0]  NVD_OFS_LINK    = 8'h0C;
   localparam logic [31:0] NVD_CFG_RST     = 32'h0FFF_FFCF;
   localparam logic [1:0]  NVD_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  NVD_RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Descriptor word fields
   // ----------------------------------------------------------------
   localparam int NVD_RD_SUP_BIT   = 31;
   localparam int NVD_WR_SUP_BIT   = 30;
   localparam int NVD_ALEN_LSB     = 28;
   localparam int NVD_D1S_CODE_LSB = 26;
   localparam int NVD_RSV_LSB      = 4;
   localparam int NVD_MODES        = 6;
   // Field base per mode: 1S count, 2S, 4S, 4S-4D, 8S, 8D
   localparam int NVD_MODE_LSB [NVD_MODES] = '{0, 22, 18, 14, 10, 6};
   localparam logic [1:0] NVD_D1S_NONE  = 2'h0;
   localparam logic [1:0] NVD_D1S_BYTE  = 2'h1;
   localparam logic [1:0] NVD_D1S_CNT   = 2'h2;
   localparam logic [1:0] NVD_D1S_UNS   = 2'h3;
   localparam logic [3:0] NVD_DUMMY_UNS = 4'hF;
   localparam logic [3:0] NVD_BYTE_CYC  = 4'h8;

   // ----------------------------------------------------------------
   // Status layouts and link framing
   // ----------------------------------------------------------------
   localparam int NVD_ST_RD_BIT     = 31;
   localparam int NVD_ST_WR_BIT     = 30;
   localparam int NVD_ST_ABYTES_LSB = 27;
   localparam int NVD_ST_MODES_LSB  = 21;
   localparam int NVD_LK_CNT_LSB    = 8;
   localparam logic [4:0] NVD_LAST_BIT = 5'h1F;

   typedef enum logic [2:0] {
      NVD_LK_IDLE  = 3'b001,
      NVD_LK_SHIFT = 3'b010,
      NVD_LK_DONE  = 3'b100
   } nvd_lk_state_t;

   // Dummy field usable unless all ones
   function automatic logic nvd_fld_ok(input logic [3:0] f);
      return f != NVD_DUMMY_UNS;
   endfunction

endpackage

// file: common/nvd_dec_if.sv
// Purpose: Decoded descriptor fields passed from decoder to top.
// Assumes: Combinational producer, single consumer.
// Notes:   Dummy counts read zero for modes unsupported by their own field; the read bit does not clear them.
`timescale 1ns/1ps
interface nvd_dec_if;
   logic             read_ok;
   logic             write_ok;
   logic [2:0]       addr_bytes;
   logic [5:0]       mode_ok;
   logic [5:0][3:0]  dummy;
   modport src (output read_ok, output write_ok, output addr_bytes,
                output mode_ok, output dummy);
   modport snk (input read_ok, input write_ok, input addr_bytes,
                input mode_ok, input dummy);
endinterface

// file: hdl/nvd_decode.sv
// Purpose: Splits the descriptor word into per-mode capabilities.
// Assumes: Word already has reserved bits cleared.
// Notes:   Pure combinational; no state.
`timescale 1ns/1ps
module nvd_decode
   import nvd_pkg::*;
(
   input  wire logic [31:0] word,
   nvd_dec_if.src           dec
);

   // ----------------------------------------------------------------
   // Field decode
   // ----------------------------------------------------------------
   // Modes unsupported by their own field report zero dummy; a clear read bit leaves the dummy counts as stored
   always_comb begin
      logic [3:0] f;
      logic [1:0] code;
      f              = 4'h0;
      code           = word[NVD_D1S_CODE_LSB +: 2];
      dec.read_ok    = word[NVD_RD_SUP_BIT];                   // R01
      dec.write_ok   = word[NVD_WR_SUP_BIT];                   // R02
      dec.addr_bytes = {1'b0, word[NVD_ALEN_LSB +: 2]} + 3'h1; // R03
      dec.mode_ok    = 6'h00;
      dec.dummy      = '0;
      // Lanes beyond single share one coding
      for (int m = 1; m < NVD_MODES; m++) begin
         f = word[NVD_MODE_LSB[m] +: 4];
         dec.mode_ok[m] = word[NVD_RD_SUP_BIT] & nvd_fld_ok(f); // R07 R08 R09 R10 R11
         dec.dummy[m]   = nvd_fld_ok(f) ? f : 4'h0;
      end
      // Single lane: byte code, or count field when code asks for it
      f = word[NVD_MODE_LSB[0] +: 4];
      unique case (code)
         NVD_D1S_NONE: begin
            dec.mode_ok[0] = word[NVD_RD_SUP_BIT]; // R05
         end
         NVD_D1S_BYTE: begin
            dec.mode_ok[0] = word[NVD_RD_SUP_BIT];
            dec.dummy[0]   = NVD_BYTE_CYC;          // R05
         end
         NVD_D1S_CNT: begin
            dec.mode_ok[0] = word[NVD_RD_SUP_BIT] & nvd_fld_ok(f); // R06
            dec.dummy[0]   = nvd_fld_ok(f) ? f : 4'h0;
         end
         NVD_D1S_UNS: begin
            dec.mode_ok[0] = 1'b0; // R05
         end
      endcase
   end

endmodule

// file: hdl/nvd_top.sv
// Purpose: Holds and publishes the non-volatile register command
//          descriptor over AXI4-Lite and a serial read-out link.
// Assumes: Link pins are asynchronous to aclk; link clock is slow
//          against aclk (at least five aclk periods per half cycle).
// Notes:   Word is snapshot at frame start so writes never tear it.
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module nvd_top
   import nvd_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        link_clk,
   input  wire logic        link_sel_n,
   output logic             link_dout
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [31:0]   cfg_r;
   logic [31:0]   desc_w;
   logic [7:0]    awaddr_r;
   logic [31:0]   wdata_r;
   logic [3:0]    wstrb_r;
   logic          aw_full_r;
   logic          w_full_r;
   logic          aw_take;
   logic          w_take;
   logic          wr_fire;
   logic          aw_full_nxt;
   logic          w_full_nxt;
   logic          bvalid_nxt;
   logic          ar_take;
   logic          rvalid_nxt;
   logic          wr_cfg;
   logic [31:0]   rd_nxt;
   logic          rd_err_nxt;
   logic [2:0]    clk_s_r;
   logic [2:0]    sel_s_r;
   logic          clk_lvl_r;
   logic          sel_lvl_r;
   logic          clk_lvl_nxt;
   logic          sel_lvl_nxt;
   logic          clk_rise;
   logic          sel_fall;
   logic          sel_rise;
   nvd_lk_state_t lk_state_r;
   logic [31:0]   shift_r;
   logic [4:0]    bit_cnt_r;
   logic [7:0]    frames_r;

   nvd_dec_if dec ();

   // ----------------------------------------------------------------
   // Descriptor assembly and decode
   // ----------------------------------------------------------------
   // Reserved pair forced low whatever software stores there
   assign desc_w = {cfg_r[31:NVD_RSV_LSB + 2], 2'b00,
                    cfg_r[NVD_RSV_LSB - 1:0]}; // R12

   nvd_decode u_decode (
      .word (desc_w),
      .dec  (dec)
   );

   // ----------------------------------------------------------------
   // AXI4-Lite write path
   // ----------------------------------------------------------------
   // Address and data taken in either order, answer after both
   always_comb begin
      aw_take     = s_axi_awvalid & s_axi_awready;
      w_take      = s_axi_wvalid & s_axi_wready;
      wr_fire     = aw_full_r & w_full_r & ~s_axi_bvalid;
      aw_full_nxt = (aw_full_r | aw_take) & ~wr_fire;
      w_full_nxt  = (w_full_r | w_take) & ~wr_fire;
      bvalid_nxt  = wr_fire | (s_axi_bvalid & ~s_axi_bready);
      wr_cfg      = wr_fire & (awaddr_r == NVD_OFS_CFG);
   end

   // Handshake state; ready stays low while a word is held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r     <= 1'b0;
         w_full_r      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
      end else begin
         aw_full_r     <= aw_full_nxt;
         w_full_r      <= w_full_nxt;
         s_axi_awready <= ~aw_full_nxt & ~bvalid_nxt;
         s_axi_wready  <= ~w_full_nxt & ~bvalid_nxt;
         s_axi_bvalid  <= bvalid_nxt;
      end
   end

   // Captured payloads
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awaddr_r <= 8'h00;
         wdata_r  <= 32'h0000_0000;
         wstrb_r  <= 4'h0;
      end else begin
         if (aw_take) begin
            awaddr_r <= s_axi_awaddr;
         end
         if (w_take) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
      end
   end

   // Only the source word is writable; anything else is refused
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bresp <= NVD_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bresp <= wr_cfg ? NVD_RESP_OKAY : NVD_RESP_SLVERR;
      end
   end

   // Source word, byte lanes honoured
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_r <= NVD_CFG_RST;
      end else if (wr_cfg) begin
         for (int b = 0; b < 4; b++) begin
            if (wstrb_r[b]) begin
               cfg_r[b*8 +: 8] <= wdata_r[b*8 +: 8];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------------------------------
   // Read mux; unmapped offsets answer zero with an error
   always_comb begin
      ar_take    = s_axi_arvalid & s_axi_arready;
      rvalid_nxt = ar_take | (s_axi_rvalid & ~s_axi_rready);
      rd_nxt     = 32'h0000_0000;
      rd_err_nxt = 1'b0;
      unique case (s_axi_araddr)
         NVD_OFS_DESC: begin
            rd_nxt = desc_w; // R12
         end
         NVD_OFS_CFG: begin
            rd_nxt = cfg_r;
         end
         NVD_OFS_DECODE: begin
            rd_nxt[NVD_ST_RD_BIT]           = dec.read_ok;  // R01
            rd_nxt[NVD_ST_WR_BIT]           = dec.write_ok; // R02
            rd_nxt[NVD_ST_ABYTES_LSB +: 3]  = dec.addr_bytes;
            rd_nxt[NVD_ST_MODES_LSB +: 6]   = dec.mode_ok;
            rd_nxt[3:0]                     = dec.dummy[0];
         end
         NVD_OFS_LINK: begin
            rd_nxt[0]                       = lk_state_r != NVD_LK_IDLE;
            rd_nxt[NVD_LK_CNT_LSB +: 8]     = frames_r;
         end
         default: begin
            rd_err_nxt = 1'b1;
         end
      endcase
   end

   // Read answer registered in the taking edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= NVD_RESP_OKAY;
      end else begin
         s_axi_arready <= ~rvalid_nxt;
         s_axi_rvalid  <= rvalid_nxt;
         if (ar_take) begin
            s_axi_rdata <= rd_nxt;
            s_axi_rresp <= rd_err_nxt ? NVD_RESP_SLVERR : NVD_RESP_OKAY;
         end
      end
   end

   // ----------------------------------------------------------------
   // Link pin synchronisers
   // ----------------------------------------------------------------
   // Three stages; a level is accepted once stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_s_r   <= 3'b000;
         sel_s_r   <= 3'b111;
         clk_lvl_r <= 1'b0;
         sel_lvl_r <= 1'b1;
      end else begin
         clk_s_r   <= {clk_s_r[1:0], link_clk};
         sel_s_r   <= {sel_s_r[1:0], link_sel_n};
         clk_lvl_r <= clk_lvl_nxt;
         sel_lvl_r <= sel_lvl_nxt;
      end
   end

   // Edge detection on the accepted levels only
   always_comb begin
      clk_lvl_nxt = (clk_s_r[1] == clk_s_r[2]) ? clk_s_r[2] : clk_lvl_r;
      sel_lvl_nxt = (sel_s_r[1] == sel_s_r[2]) ? sel_s_r[2] : sel_lvl_r;
      clk_rise    = clk_lvl_nxt & ~clk_lvl_r;
      sel_fall    = ~sel_lvl_nxt & sel_lvl_r;
      sel_rise    = sel_lvl_nxt & ~sel_lvl_r;
   end

   // ----------------------------------------------------------------
   // Serial read-out of the descriptor
   // ----------------------------------------------------------------
   // Msb first; host samples on link clock rise, next bit follows
   // that rise, so a bit stands for a whole link period
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lk_state_r <= NVD_LK_IDLE;
         shift_r    <= 32'h0000_0000;
         bit_cnt_r  <= 5'h00;
         link_dout  <= 1'b0;
      end else if (sel_rise) begin
         lk_state_r <= NVD_LK_IDLE;
         link_dout  <= 1'b0;
      end else begin
         unique case (lk_state_r)
            NVD_LK_IDLE: begin
               if (sel_fall) begin
                  lk_state_r <= NVD_LK_SHIFT;
                  shift_r    <= desc_w; // R12
                  bit_cnt_r  <= 5'h00;
                  link_dout  <= desc_w[31];
               end
            end
            NVD_LK_SHIFT: begin
               if (clk_rise) begin
                  if (bit_cnt_r == NVD_LAST_BIT) begin
                     lk_state_r <= NVD_LK_DONE;
                     link_dout  <= 1'b0;
                  end else begin
                     shift_r   <= {shift_r[30:0], 1'b0};
                     bit_cnt_r <= bit_cnt_r + 5'h01;
                     link_dout <= shift_r[30];
                  end
               end
            end
            NVD_LK_DONE: begin
               link_dout <= 1'b0;
            end
            default: begin
               lk_state_r <= NVD_LK_IDLE;
               link_dout  <= 1'b0;
            end
         endcase
      end
   end

   // Completed frames, wraps at 255
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frames_r <= 8'h00;
      end else if (lk_state_r == NVD_LK_SHIFT && clk_rise
                   && bit_cnt_r == NVD_LAST_BIT && !sel_rise) begin
         frames_r <= frames_r + 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_rd_sup;
      !desc_w[NVD_RD_SUP_BIT] |-> dec.mode_ok == 6'h00;
   endproperty
   a_rd_sup: assert property (p_rd_sup) // R01
      else $error("mode allowed while read unsupported");

   property p_wr_sup;
      wr_cfg && wstrb_r[3] && !wdata_r[NVD_WR_SUP_BIT] |=> !dec.write_ok;
   endproperty
   a_wr_sup: assert property (p_wr_sup) // R02
      else $error("write support stays after clear");

   property p_alen;
      dec.addr_bytes == (desc_w[29:28] == 2'h0 ? 3'h1 : desc_w[29:28] == 2'h1 ? 3'h2
                       : desc_w[29:28] == 2'h2 ? 3'h3 : 3'h4);
   endproperty
   a_alen: assert property (p_alen) // R03
      else $error("address byte count wrong");

   property p_d1s_code;
      (desc_w[27:26] == NVD_D1S_UNS |-> !dec.mode_ok[0])
      and (desc_w[27:26] == NVD_D1S_BYTE |-> dec.dummy[0] == 4'h8)
      and (desc_w[27:26] == NVD_D1S_NONE |-> dec.dummy[0] == 4'h0);
   endproperty
   a_d1s_code: assert property (p_d1s_code) // R05
      else $error("single lane dummy code misdecoded");

   property p_d1s_cnt;
      desc_w[27:26] == NVD_D1S_CNT |->
         dec.mode_ok[0] == (desc_w[31] && desc_w[3:0] != 4'hF)
         && (desc_w[3:0] == 4'hF || dec.dummy[0] == desc_w[3:0]);
   endproperty
   a_d1s_cnt: assert property (p_d1s_cnt) // R06
      else $error("single lane count misdecoded");

   property p_d2s;
      desc_w[31] |-> dec.mode_ok[1] == (desc_w[25:22] != 4'hF)
         && dec.dummy[1] == (desc_w[25:22] == 4'hF ? 4'h0 : desc_w[25:22]);
   endproperty
   a_d2s: assert property (p_d2s) // R07
      else $error("dual lane dummy misdecoded");

   property p_d4s;
      desc_w[31] && desc_w[21:18] != 4'hF |->
         dec.mode_ok[2] && dec.dummy[2] == desc_w[21:18];
   endproperty
   a_d4s: assert property (p_d4s) // R08
      else $error("quad single rate dummy misdecoded");

   property p_d4d;
      desc_w[17:14] == 4'hF |-> !dec.mode_ok[3] && dec.dummy[3] == 4'h0;
   endproperty
   a_d4d: assert property (p_d4d) // R09
      else $error("quad double rate unsupported not flagged");

   property p_d8s;
      $changed(desc_w[13:10]) && desc_w[31] |->
         dec.mode_ok[4] == (desc_w[13:10] != 4'hF);
   endproperty
   a_d8s: assert property (p_d8s) // R10
      else $error("octal single rate support misdecoded");

   property p_d8d;
      desc_w[31] && desc_w[9:6] != 4'hF |->
         dec.mode_ok[5] && dec.dummy[5] == desc_w[9:6];
   endproperty
   a_d8d: assert property (p_d8d) // R11
      else $error("octal double rate dummy misdecoded");

   property p_rsv;
      ar_take && s_axi_araddr == NVD_OFS_DESC |=> s_axi_rvalid
         && s_axi_rdata[5:4] == 2'b00 && s_axi_rdata[31:6] == $past(cfg_r[31:6]);
   endproperty
   a_rsv: assert property (p_rsv) // R12
      else $error("descriptor read shows reserved bits or stale word");

endmodule

// file: sim/nvd_link_host.sv
// Purpose: Host side of the serial read-out link; reads one descriptor word.
// Assumes: Link pins are asynchronous to aclk; clock stands low outside frames.
// Notes:   Timing is set per frame so fast and slow hosts can be mixed.
`timescale 1ns/1ps
module nvd_link_host (
   output logic      link_clk,
   output logic      link_sel_n,
   input  wire logic link_dout
);

   // ----------------------------------------------------------------
   // Idle levels
   // ----------------------------------------------------------------
   // Deselected and clock parked low until a frame is asked for
   initial begin
      link_clk = 1'b0;
      link_sel_n = 1'b1;
   end

   // ----------------------------------------------------------------
   // Frame read
   // ----------------------------------------------------------------
   // Odd lead-in keeps the link phase unrelated to aclk
   task automatic read_frame(input int half_ns, output logic [31:0] w);
      #(half_ns + 13);
      link_sel_n = 1'b0;
      #(half_ns + 13);
      // Sample just before each rise, MSB first
      for (int k = 31; k >= 0; k--) begin
         w[k] = link_dout;
         link_clk = 1'b1;
         #(half_ns);
         link_clk = 1'b0;
         #(half_ns);
      end
      link_sel_n = 1'b1;
      #(half_ns + 13);
   endtask

endmodule

// file: sim/test_nvd_top.sv
// Purpose: Self-checking bench for the descriptor block over AXI4-Lite and link.
// Assumes: Single write and single read at a time; link host model in place.
// Notes:   Expected decode is rebuilt here from the field coding.
`timescale 1ns/1ps
module test_nvd_top
   import nvd_pkg::*;
;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d, w, last;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic        link_clk, link_sel_n, link_dout;
   int          err_total, checked;
   // Covers every address code, every single-lane code, counts 0, 14 and 15
   logic [31:0] words [6] = '{32'h8000_0000, 32'hC400_0030, 32'h5B9E_73AE,
                              32'hABFF_FFFF, 32'hE800_0000, 32'hFC00_0000};

   // ----------------------------------------------------------------
   // Design and link host
   // ----------------------------------------------------------------
   nvd_top nvd_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .link_clk(link_clk), .link_sel_n(link_sel_n),
      .link_dout(link_dout));

   nvd_link_host nvd_link_host_i (.link_clk(link_clk), .link_sel_n(link_sel_n),
      .link_dout(link_dout));

   // ----------------------------------------------------------------
   // Clock and watchdog
   // ----------------------------------------------------------------
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   // Cuts a hang short well inside the cycle budget
   initial begin
      #500000;
      err_total++;
      print_verdict;
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic print_verdict;
      if (err_total == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Decode status rebuilt from the field coding
   function automatic logic [31:0] exp_dec(input logic [31:0] v);
      logic [31:0] e;
      int          lsb [5] = '{22, 18, 14, 10, 6};
      e = 32'h0000_0000;
      e[31] = v[31];
      e[30] = v[30];
      e[29:27] = {1'b0, v[29:28]} + 3'h1;
      e[21] = v[31] & (v[27:26] != 2'h3) & ((v[27:26] != 2'h2) | (v[3:0] != 4'hF));
      for (int m = 0; m < 5; m++) begin
         e[22 + m] = v[31] & (v[lsb[m] +: 4] != 4'hF);
      end
      case (v[27:26])
         2'h1: e[3:0] = 4'h8;
         2'h2: e[3:0] = (v[3:0] != 4'hF) ? v[3:0] : 4'h0;
         default: e[3:0] = 4'h0;
      endcase
      return e;
   endfunction

   // Ready seen mid-cycle means the take lands on the next rise
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] dv, input logic [3:0] s,
                         output logic [1:0] rs);
      logic ta, tw, tb, done;
      done = 1'b0;
      rs = 2'h3;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= dv;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 100 && !done; n++) begin
         @(negedge aclk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bvalid;
         rs = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
         done = tb;
      end
      if (!done) begin
         err_total++;
         print_verdict;
      end
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
      logic ta, tr, done;
      done = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 100 && !done; n++) begin
         @(negedge aclk);
         ta = arvalid & arready;
         tr = rvalid;
         dv = rdata;
         rs = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
         if (tr) rready <= 1'b0;
         done = tr;
      end
      if (!done) begin
         err_total++;
         print_verdict;
      end
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0000_0000;
      wstrb = 4'h0;
      err_total = 0;
      checked = 0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (6) @(posedge aclk);
      // Reset contents: nothing supported, reserved bits clear
      axi_rd(NVD_OFS_CFG, d, r);
      check("cfg reset", d, NVD_CFG_RST);
      axi_rd(NVD_OFS_DESC, d, r);
      check("desc reset", d, NVD_CFG_RST & 32'hFFFF_FFCF);
      axi_rd(NVD_OFS_DECODE, d, r);
      check("decode reset", d, exp_dec(NVD_CFG_RST));
      axi_rd(NVD_OFS_LINK, d, r);
      check("link reset", d, 32'h0000_0000);
      // Every field coding, back to back
      foreach (words[i]) begin
         axi_wr(NVD_OFS_CFG, words[i], 4'hF, r);
         check("cfg resp", {30'h0, r}, {30'h0, NVD_RESP_OKAY});
         axi_rd(NVD_OFS_DESC, d, r);
         check("desc", d, words[i] & 32'hFFFF_FFCF);
         axi_rd(NVD_OFS_DECODE, d, r);
         check("decode", d, exp_dec(words[i]));
      end
      // Word on the wire, two frames at the 80 ns link period
      nvd_link_host_i.read_frame(40, w);
      check("link word first", w, words[5] & 32'hFFFF_FFCF);
      axi_wr(NVD_OFS_CFG, words[2], 4'hF, r);
      nvd_link_host_i.read_frame(40, w);
      check("link word second", w, words[2] & 32'hFFFF_FFCF);
      axi_rd(NVD_OFS_LINK, d, r);
      check("link count", d, 32'h0000_0200);
      // Read-only and unmapped places refuse and keep the word
      axi_wr(NVD_OFS_DESC, 32'h0000_0000, 4'hF, r);
      check("ro wr resp", {30'h0, r}, {30'h0, NVD_RESP_SLVERR});
      axi_wr(8'h10, 32'h0000_0000, 4'hF, r);
      check("unmapped wr resp", {30'h0, r}, {30'h0, NVD_RESP_SLVERR});
      axi_rd(8'h10, d, r);
      check("unmapped rd data", d, 32'h0000_0000);
      check("unmapped rd resp", {30'h0, r}, {30'h0, NVD_RESP_SLVERR});
      axi_rd(NVD_OFS_CFG, d, r);
      check("cfg kept", d, words[2]);
      // Low byte only: count field, reserved pair and low bits of the 8D field change, the rest holds
      last = {words[2][31:8], 8'hF5};
      axi_wr(NVD_OFS_CFG, 32'h1234_56F5, 4'h1, r);
      axi_rd(NVD_OFS_DECODE, d, r);
      check("strobe decode", d, exp_dec(last));
      axi_rd(NVD_OFS_DESC, d, r);
      check("strobe desc", d, last & 32'hFFFF_FFCF);
      print_verdict;
   end

endmodule
